// file: cs_pkg.sv
// Package: constants and types for the boot configuration script interpreter
package cs_pkg;

  // Script geometry
  localparam int unsigned SCRIPT_WORDS    = 60;
  localparam int unsigned SCRIPT_BYTES    = 240;
  localparam int unsigned IDX_W           = 6;
  localparam logic [5:0]  LAST_IDX        = 6'h3B;

  // Command words and patterns
  localparam logic [31:0] START_WORD      = 32'hA5A5A5A5;
  localparam logic [31:0] ERASED_WORD     = 32'hFFFFFFFF;
  localparam logic [31:0] DBG_OFF_WORD    = 32'h70000000;
  localparam logic [31:0] SPI_FAST_WORD   = 32'hA0000000;
  localparam logic [3:0]  WAIT_NIBBLE     = 4'h8;
  localparam logic [15:0] SKIP_TAG        = 16'h9000;

  // Field positions
  localparam int unsigned WAIT_LSB        = 0;
  localparam int unsigned WAIT_W          = 28;
  localparam int unsigned INDEX_LSB       = 0;
  localparam int unsigned COUNT_LSB       = 8;

  // Values after reset
  localparam logic [27:0] WAIT_RESET      = 28'h0000000;
  localparam logic [27:0] WAIT_DEFAULT    = 28'h0000000;
  localparam int unsigned WAIT_UNIT_US    = 100;
  localparam int unsigned SPI_SLOW_MHZ    = 2;
  localparam int unsigned SPI_FAST_MHZ    = 32;

  // Interpreter states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_READ  = 3'b001,
    ST_WAIT  = 3'b010,
    ST_DECO  = 3'b011,
    ST_WRITE = 3'b100,
    ST_DONE  = 3'b101
  } cs_state_t;

endpackage

// file: cs_word_reader.sv
// Script word reader: one memory read per request, data registered
`timescale 1ns/1ps
module cs_word_reader
  import cs_pkg::*;
(
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          rst_b,
  // Request from interpreter
  input  wire logic          req,
  input  wire logic [5:0]    idx,
  // Memory port
  output logic               mem_rd,
  output logic [5:0]         mem_idx,
  input  wire logic          mem_vld,
  input  wire logic [31:0]   mem_data,
  // Word to interpreter
  output logic               word_vld,
  output logic [31:0]        word
);
  import cs_pkg::*;

  typedef struct packed {
    logic        busy;
    logic        vld;
    logic [31:0] word;
  } rd_st_t;

  rd_st_t st_ff;
  rd_st_t nxt_st;

  // Next state of the reader
  always_comb begin
    nxt_st     = st_ff;
    nxt_st.vld = 1'b0;
    if (req && !st_ff.busy) begin
      nxt_st.busy = 1'b1;
    end else if (st_ff.busy && mem_vld) begin
      nxt_st.busy = 1'b0;
      nxt_st.vld  = 1'b1;
      nxt_st.word = mem_data;
    end
  end

  // State register
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Memory address only reaches inside the script area
  assign mem_rd   = req && !st_ff.busy;
  assign mem_idx  = (idx > LAST_IDX) ? LAST_IDX : idx;  // [R14]
  assign word_vld = st_ff.vld;
  assign word     = st_ff.word;
endmodule

// file: cs_reg_writer.sv
// System bus writer: holds one address/data pair until accepted
`timescale 1ns/1ps
module cs_reg_writer
  import cs_pkg::*;
(
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          rst_b,
  // Request from interpreter
  input  wire logic          req,
  input  wire logic [31:0]   addr,
  input  wire logic [31:0]   data,
  output logic               done,
  // System bus
  output logic               bus_wr,
  output logic [31:0]        bus_addr,
  output logic [31:0]        bus_wdata,
  input  wire logic          bus_ack
);
  import cs_pkg::*;

  typedef struct packed {
    logic        busy;
    logic        done;
    logic [31:0] addr;
    logic [31:0] data;
  } wr_st_t;

  wr_st_t st_ff;
  wr_st_t nxt_st;

  // Capture request, hold until the bus acknowledges
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.done = 1'b0;
    if (req && !st_ff.busy) begin
      nxt_st.busy = 1'b1;
      nxt_st.addr = addr;
      nxt_st.data = data;
    end else if (st_ff.busy && bus_ack) begin
      nxt_st.busy = 1'b0;
      nxt_st.done = 1'b1;
    end
  end

  // State register
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign bus_wr    = st_ff.busy;
  assign bus_addr  = st_ff.addr;
  assign bus_wdata = st_ff.data;
  assign done      = st_ff.done;
endmodule

// file: boot_config_script_interpreter.sv
// Boot configuration script interpreter: walks the script and applies it
`timescale 1ns/1ps

// Memory and bus latency are open-ended: a silent memory or bus
// stalls the walk, and nothing here times it out.

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// R1: Script is up to sixty 32-bit words
// R2: Valid only if first word is marker
// R3: Even word address, odd word data, write
// R4: Skip-tagged header: following words never written
// R5: Writer keeps calibration indices increasing
// R6: Debug-off word sets debugger-disable flag
// R7: Top nibble 8 loads UART wait
// R8: Fast SPI word selects 32 MHz clock
// R9: Stop at first erased word
// R10: Finish before processor runs application
// R11: Entries in order; later writes win
// R12: No boot device: rescan or debug loop
// R13: No marker: no writes, defaults kept
// R14: Never read past sixtieth word
module boot_config_script_interpreter
  import cs_pkg::*;
(
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          rst_b,
  // Boot control
  input  wire logic          start,
  output logic               busy,
  output logic               script_done,
  output logic               script_valid,
  output logic               cpu_release,
  // Script memory port
  output logic               mem_rd,
  output logic [5:0]         mem_idx,
  input  wire logic          mem_vld,
  input  wire logic [31:0]   mem_data,
  // System register bus
  output logic               bus_wr,
  output logic [31:0]        bus_addr,
  output logic [31:0]        bus_wdata,
  input  wire logic          bus_ack,
  // Captured settings
  output logic [27:0]        uart_boot_start_wait,
  output logic               spi_fast_clk,
  output logic               dbg_disable,
  // Calibration bookkeeping
  output logic [5:0]         software_kit_value_count,
  output logic [5:0]         software_kit_value_first,
  output logic [7:0]         calibration_index,
  // End-of-boot decision
  input  wire logic          no_boot_device,
  output logic               rescan_periph,
  output logic               debug_port_en,
  output logic               idle_loop
);
  import cs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    // Walk position
    cs_state_t   state;
    logic [5:0]  idx;

    // Pair and payload tracking
    logic [7:0]  skip_left;
    logic [31:0] addr;
    logic        have_addr;

    // Progress of the run
    logic        valid;
    logic        done;

    // Settings taken from command words
    logic [27:0] wait_val;
    logic        spi_fast;
    logic        dbg_off;

    // Calibration bookkeeping
    logic [5:0]  cal_count;
    logic [5:0]  cal_first;
    logic [7:0]  cal_index;

    // End-of-boot outcome
    logic        rescan;
    logic        dbg_en;
    logic        idle;
  } top_st_t;

  top_st_t st_ff;
  top_st_t nxt_st;

  // Reader and writer handshakes
  logic        rd_req;
  logic        word_vld;
  logic [31:0] word;
  logic        wr_req;
  logic        wr_done;
  logic [31:0] wr_data;
  logic        last_word;

  // Word classification
  logic        is_erased;
  logic        is_marker;
  logic        is_dbg_off;
  logic        is_spi_fast;
  logic        is_wait_cmd;
  logic        is_skip_hdr;

  // Walk position and end-of-boot outcome
  logic        at_first;
  logic        at_even;
  logic [5:0]  idx_next;
  logic        want_rescan;
  logic        want_loop;

  ////////////////////////////////////////////////////////////////////////////
  // Submodules

  // Word fetch from the script area
  cs_word_reader u_reader (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .req      (rd_req),
    .idx      (st_ff.idx),
    .mem_rd   (mem_rd),
    .mem_idx  (mem_idx),
    .mem_vld  (mem_vld),
    .mem_data (mem_data),
    .word_vld (word_vld),
    .word     (word)
  );

  // Register write on the system bus
  cs_reg_writer u_writer (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .req       (wr_req),
    .addr      (st_ff.addr),
    .data      (wr_data),
    .done      (wr_done),
    .bus_wr    (bus_wr),
    .bus_addr  (bus_addr),
    .bus_wdata (bus_wdata),
    .bus_ack   (bus_ack)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Interpreter

  assign last_word = (st_ff.idx == LAST_IDX);  // [R1]

  // Command words matched whole
  assign is_erased   = (word == ERASED_WORD);  // [R9]
  assign is_marker   = (word == START_WORD);  // [R2]
  assign is_dbg_off  = (word == DBG_OFF_WORD);  // [R6]
  assign is_spi_fast = (word == SPI_FAST_WORD);  // [R8]

  // Command words matched by their tag field
  assign is_wait_cmd = (word[31:28] == WAIT_NIBBLE);  // [R7]
  assign is_skip_hdr = (word[31:16] == SKIP_TAG);  // [R4]

  // Where the walk stands in the script
  assign at_first = (st_ff.idx == 6'h00);
  assign at_even  = !st_ff.idx[0];  // [R3]
  assign idx_next = st_ff.idx + 6'h01;

  // End-of-boot outcome when no peripheral answered
  assign want_rescan = no_boot_device && st_ff.dbg_off;  // [R12]
  assign want_loop   = no_boot_device && !st_ff.dbg_off;  // [R12]

  // Next state of the interpreter
  always_comb begin
    nxt_st  = st_ff;
    rd_req  = 1'b0;
    wr_req  = 1'b0;
    wr_data = word;
    case (st_ff.state)
      // Wait for start; every run begins from defaults
      ST_IDLE: begin
        if (start) begin
          nxt_st.state     = ST_READ;
          nxt_st.idx       = '0;
          nxt_st.have_addr = 1'b0;
          nxt_st.skip_left = '0;
          nxt_st.valid     = 1'b0;
          nxt_st.done      = 1'b0;
          nxt_st.wait_val  = WAIT_DEFAULT;  // [R13]
          nxt_st.spi_fast  = 1'b0;  // [R13]
          nxt_st.dbg_off   = 1'b0;  // [R13]
          nxt_st.cal_count = '0;
          nxt_st.cal_first = '0;
          nxt_st.cal_index = '0;
          nxt_st.rescan    = 1'b0;  // [R12]
          nxt_st.dbg_en    = 1'b0;
          nxt_st.idle      = 1'b0;
        end
      end

      // One read request, then wait for the word
      ST_READ: begin
        rd_req       = 1'b1;
        nxt_st.state = ST_WAIT;
      end

      // Memory latency is open-ended; the reader flags the word
      ST_WAIT: begin
        if (word_vld) begin
          nxt_st.state = ST_DECO;
        end
      end

      // Interpret one word; payload and data slots win over every command but the erased word
      ST_DECO: begin
        nxt_st.state = ST_READ;
        if (is_erased) begin
          nxt_st.state = ST_DONE;  // [R9]
        end else if (at_first) begin
          // Opening word decides whether anything is applied
          if (is_marker) begin
            nxt_st.valid = 1'b1;  // [R2]
          end else begin
            nxt_st.state = ST_DONE;  // [R13]
          end
        end else if (st_ff.skip_left != '0) begin
          // Calibration payload left for software
          nxt_st.skip_left = st_ff.skip_left - 8'h01;  // [R4]
        end else if (st_ff.have_addr) begin
          // Odd word of a pair: write it in order
          wr_req           = 1'b1;  // [R3] [R11]
          nxt_st.have_addr = 1'b0;
          nxt_st.state     = ST_WRITE;
        end else if (is_dbg_off) begin
          nxt_st.dbg_off = 1'b1;  // [R6]
        end else if (is_spi_fast) begin
          nxt_st.spi_fast = 1'b1;  // [R8]
        end else if (is_wait_cmd) begin
          nxt_st.wait_val = word[WAIT_LSB +: WAIT_W];  // [R7]
        end else if (is_skip_hdr) begin
          // Header: count and index kept, payload follows
          nxt_st.skip_left = word[COUNT_LSB +: 8];  // [R4]
          nxt_st.cal_index = word[INDEX_LSB +: 8];
          nxt_st.cal_first = idx_next;
          nxt_st.cal_count = st_ff.cal_count + 6'h01;
        end else if (at_even) begin
          // Address slot of a register pair
          nxt_st.addr      = word;  // [R3]
          nxt_st.have_addr = 1'b1;
        end
        // Next word, unless the script area is used up
        if (nxt_st.state == ST_READ) begin
          if (last_word) begin
            nxt_st.state = ST_DONE;  // [R14]
          end else begin
            nxt_st.idx = idx_next;
          end
        end
      end

      // Hold until the bus takes the pair
      ST_WRITE: begin
        if (wr_done) begin
          if (last_word) begin
            nxt_st.state = ST_DONE;  // [R14]
          end else begin
            nxt_st.idx   = idx_next;
            nxt_st.state = ST_READ;
          end
        end
      end

      // Script finished; start honoured once the end is visible
      ST_DONE: begin
        nxt_st.done   = 1'b1;  // [R10]
        nxt_st.rescan = want_rescan;  // [R12]
        if (want_loop) begin
          nxt_st.dbg_en = 1'b1;  // [R12]
          nxt_st.idle   = 1'b1;
        end
        if (start && st_ff.done) begin
          nxt_st.state = ST_IDLE;
        end
      end

      // Any unused code returns to idle
      default: begin
        nxt_st.state = ST_IDLE;
      end
    endcase
  end

  // State register; every field starts from its reset value
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff.state     <= ST_IDLE;
      st_ff.idx       <= '0;
      st_ff.skip_left <= '0;
      st_ff.addr      <= '0;
      st_ff.have_addr <= 1'b0;
      st_ff.valid     <= 1'b0;
      st_ff.done      <= 1'b0;
      st_ff.wait_val  <= WAIT_RESET;
      st_ff.spi_fast  <= 1'b0;
      st_ff.dbg_off   <= 1'b0;
      st_ff.cal_count <= '0;
      st_ff.cal_first <= '0;
      st_ff.cal_index <= '0;
      st_ff.rescan    <= 1'b0;
      st_ff.dbg_en    <= 1'b0;
      st_ff.idle      <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Progress and handover to the processor
  assign busy         = (st_ff.state != ST_IDLE) && !st_ff.done;
  assign script_done  = st_ff.done;
  assign script_valid = st_ff.valid;
  assign cpu_release  = st_ff.done;  // [R10]

  // Settings captured from command words
  assign uart_boot_start_wait = st_ff.wait_val;  // [R7]
  assign spi_fast_clk         = st_ff.spi_fast;  // [R8]
  assign dbg_disable          = st_ff.dbg_off;  // [R6]

  // Calibration bookkeeping for software
  assign software_kit_value_count = st_ff.cal_count;  // [R4]
  assign software_kit_value_first = st_ff.cal_first;
  assign calibration_index        = st_ff.cal_index;

  // End-of-boot outcome
  assign rescan_periph = st_ff.rescan;  // [R12]
  assign debug_port_en = st_ff.dbg_en;
  assign idle_loop     = st_ff.idle;
endmodule

// file: cs_checker_assertions.sv
// Checker: port rules of the boot script interpreter
`timescale 1ns/1ps
module cs_checker (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst_b,
  // Control and status
  input wire logic        start,
  input wire logic        busy,
  input wire logic        script_done,
  input wire logic        script_valid,
  input wire logic        cpu_release,
  // Memory and bus
  input wire logic        mem_rd,
  input wire logic [5:0]  mem_idx,
  input wire logic        bus_wr,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic        bus_ack,
  // Settings and end of boot
  input wire logic [27:0] uart_boot_start_wait,
  input wire logic        spi_fast_clk,
  input wire logic        dbg_disable,
  input wire logic        no_boot_device,
  input wire logic        rescan_periph,
  input wire logic        debug_port_en,
  input wire logic        idle_loop
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////
  // Properties and their assertions
  property p_idx;
    mem_rd |-> mem_idx <= 6'h3B;
  endproperty
  a_idx: assert property (p_idx) else $error("read beyond script area");
  property p_first;
    !busy && !script_done && start |-> ##[1:2] (mem_rd && mem_idx == 6'h00);
  endproperty
  a_first: assert property (p_first) else $error("first read not word zero");
  property p_one;
    mem_rd |=> !mem_rd;
  endproperty
  a_one: assert property (p_one) else $error("reads back to back");
  property p_hold;
    bus_wr && !bus_ack |=> bus_wr && $stable(bus_addr) && $stable(bus_wdata);
  endproperty
  a_hold: assert property (p_hold) else $error("bus write dropped early");
  property p_valid;
    bus_wr |-> script_valid;
  endproperty
  a_valid: assert property (p_valid) else $error("write without marker");
  property p_cpu;
    (busy |-> !cpu_release) and (script_done |-> cpu_release);
  endproperty
  a_cpu: assert property (p_cpu) else $error("processor release wrong");
  property p_stop;
    script_done && !start |=> !mem_rd && $stable(uart_boot_start_wait)
      && $stable(spi_fast_clk) && $stable(dbg_disable);
  endproperty
  a_stop: assert property (p_stop) else $error("activity after end");
  property p_rescan;
    script_done && no_boot_device && dbg_disable |-> ##[0:3]
      (rescan_periph && !debug_port_en && !idle_loop);
  endproperty
  a_rescan: assert property (p_rescan) else $error("no rescan");
  property p_loop;
    script_done && no_boot_device && !dbg_disable |-> ##[0:3]
      (debug_port_en && idle_loop && !rescan_periph);
  endproperty
  a_loop: assert property (p_loop) else $error("no debug loop");
  // Main scenarios reached
  c_write: cover property (bus_wr && bus_ack);
  c_rescan: cover property (rescan_periph);
  c_loop: cover property (idle_loop);
endmodule
bind boot_config_script_interpreter cs_checker cs_checker_i (
  .mclk, .rst_b, .start, .busy, .script_done, .script_valid, .cpu_release, .mem_rd,
  .mem_idx, .bus_wr, .bus_addr, .bus_wdata, .bus_ack, .uart_boot_start_wait,
  .spi_fast_clk, .dbg_disable, .no_boot_device, .rescan_periph, .debug_port_en, .idle_loop
);

// file: cs_partner.sv
// Partner: script memory and register bus slave
`timescale 1ns/1ps
module cs_partner (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst_b,
  // Script memory
  input wire logic        mem_rd,
  input wire logic [5:0]  mem_idx,
  output logic            mem_vld,
  output logic [31:0]     mem_data,
  // Register bus
  input wire logic        bus_wr,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  output logic            bus_ack
);
  logic [31:0] rom [60]; // Script area, sixty words
  logic [31:0] wa [$];
  logic [31:0] wd [$];
  logic [5:0]  ri;
  int          lat;
  int          rc;
  int          bc;
  ////////////////////////////////////////
  // Memory answers after lat cycles, data churns otherwise
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mem_vld <= 1'b0;
      mem_data <= 32'h0;
      rc <= -1;
    end else begin
      mem_vld <= (rc == 0) && !mem_rd;
      mem_data <= ((rc == 0) && !mem_rd) ? rom[ri] : ~mem_data;
      if (mem_rd) begin
        ri <= mem_idx;
        rc <= lat;
      end else if (rc >= 0) begin
        rc <= rc - 1;
      end
    end
  end
  // Bus accepts after lat cycles and logs in order
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bus_ack <= 1'b0;
      bc <= 0;
    end else begin
      bus_ack <= bus_wr && !bus_ack && (bc >= lat);
      if (bus_wr && !bus_ack) begin
        if (bc >= lat) begin
          bc <= 0;
          wa.push_back(bus_addr); // Kept in arrival order
          wd.push_back(bus_wdata);
        end else begin
          bc <= bc + 1;
        end
      end
    end
  end
endmodule

// file: boot_config_script_interpreter_bench.sv
// Testbench: boot configuration script interpreter
`timescale 1ns/1ps
module boot_config_script_interpreter_bench;
  import cs_pkg::*;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic        start = 1'b0;
  logic        no_boot_device = 1'b0;
  logic        busy, script_done, script_valid, cpu_release;
  logic        mem_rd, mem_vld, bus_wr, bus_ack;
  logic [5:0]  mem_idx, kit_count, kit_first;
  logic [31:0] mem_data, bus_addr, bus_wdata;
  logic [27:0] uart_boot_start_wait;
  logic        spi_fast_clk, dbg_disable, rescan_periph, debug_port_en, idle_loop;
  logic [7:0]  calibration_index;
  int          failures = 0;
  int          n_checks = 0;
  ////////////////////////////////////////
  // Clock, design and partner
  always #4 mclk = ~mclk;
  boot_config_script_interpreter boot_config_script_interpreter_i (
    .mclk, .rst_b, .start, .busy, .script_done, .script_valid, .cpu_release, .mem_rd,
    .mem_idx, .mem_vld, .mem_data, .bus_wr, .bus_addr, .bus_wdata, .bus_ack,
    .uart_boot_start_wait, .spi_fast_clk, .dbg_disable,
    .software_kit_value_count(kit_count), .software_kit_value_first(kit_first),
    .calibration_index, .no_boot_device, .rescan_periph, .debug_port_en, .idle_loop
  );
  cs_partner cs_partner_i (
    .mclk, .rst_b, .mem_rd, .mem_idx, .mem_vld, .mem_data, .bus_wr, .bus_addr,
    .bus_wdata, .bus_ack
  );
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Reset with erased script and chosen latency
  task automatic do_reset(input int l, input logic nb);
    @(posedge mclk);
    cs_partner_i.lat = l;
    cs_partner_i.wa.delete();
    cs_partner_i.wd.delete();
    foreach (cs_partner_i.rom[i]) cs_partner_i.rom[i] = 32'hFFFFFFFF;
    rst_b <= 1'b0;
    no_boot_device <= nb;
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
  endtask
  // Start and wait for the end of the script
  task automatic run_script();
    int n;
    n = 0;
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    @(negedge mclk);
    while (script_done !== 1'b1 && n < 5000) begin
      @(negedge mclk);
      n++;
    end
    repeat (4) @(negedge mclk);
    check(32'(script_done), 32'h1);
    check(32'(cpu_release), 32'h1);
    check(32'(busy), 32'h0);
  endtask
  // Mixed script as written in production, then patched
  task automatic t_full();
    do_reset(0, 1'b1);
    cs_partner_i.rom[0] = 32'hA5A5A5A5;
    cs_partner_i.rom[1] = 32'h80000028;
    cs_partner_i.rom[2] = 32'h40000010;
    cs_partner_i.rom[3] = 32'h11111111;
    cs_partner_i.rom[4] = 32'h90000301;
    cs_partner_i.rom[5] = 32'h22222222;
    cs_partner_i.rom[6] = 32'h80000001;
    cs_partner_i.rom[7] = 32'h22222222;
    cs_partner_i.rom[8] = 32'h40000020;
    cs_partner_i.rom[9] = 32'h33333333;
    cs_partner_i.rom[10] = 32'h40000010;
    cs_partner_i.rom[11] = 32'h44444444;
    cs_partner_i.rom[12] = 32'h90000402;
    for (int i = 13; i < 17; i++) cs_partner_i.rom[i] = 32'h55555555;
    cs_partner_i.rom[17] = 32'h70000000;
    cs_partner_i.rom[18] = 32'hA0000000;
    cs_partner_i.rom[20] = 32'h40000030;
    cs_partner_i.rom[21] = 32'h66666666;
    run_script();
    check(32'(script_valid), 32'h1);
    check(32'(uart_boot_start_wait), 32'h00000028);
    check(32'(spi_fast_clk), 32'h1);
    check(32'(dbg_disable), 32'h1);
    check(32'(kit_count), 32'h2);
    check(32'(kit_first), 32'h0000000D);
    check(32'(calibration_index), 32'h2);
    check(32'(cs_partner_i.wa.size()), 32'h3);
    check(cs_partner_i.wa[0], 32'h40000010);
    check(cs_partner_i.wd[0], 32'h11111111);
    check(cs_partner_i.wa[1], 32'h40000020);
    check(cs_partner_i.wd[1], 32'h33333333);
    check(cs_partner_i.wd[2], 32'h44444444);
    check(32'({rescan_periph, debug_port_en, idle_loop}), 32'h4);
  endtask
  // Opening word is a command, not the marker
  task automatic t_no_marker();
    do_reset(3, 1'b1);
    cs_partner_i.rom[0] = 32'h70000000;
    cs_partner_i.rom[1] = 32'hA0000000;
    cs_partner_i.rom[2] = 32'h40000010;
    cs_partner_i.rom[3] = 32'h11111111;
    run_script();
    check(32'(script_valid), 32'h0);
    check(32'({uart_boot_start_wait, spi_fast_clk, dbg_disable}), 32'h0);
    check(32'(cs_partner_i.wa.size()), 32'h0);
    check(32'({rescan_periph, debug_port_en, idle_loop}), 32'h3);
  endtask
  // Sixty words with no erased entry
  task automatic t_sixty();
    do_reset(2, 1'b0);
    cs_partner_i.rom[0] = 32'hA5A5A5A5;
    cs_partner_i.rom[1] = 32'h8FFFFFFF;
    for (int i = 2; i < 60; i += 2) begin
      cs_partner_i.rom[i] = 32'h40000000 + 32'(i);
      cs_partner_i.rom[i + 1] = 32'h00000100 + 32'(i);
    end
    run_script();
    check(32'(uart_boot_start_wait), 32'h0FFFFFFF);
    check(32'(cs_partner_i.wa.size()), 32'h0000001D);
    check(cs_partner_i.wa[28], 32'h4000003A);
    check(cs_partner_i.wd[28], 32'h0000013A);
    check(32'({rescan_periph, debug_port_en, idle_loop}), 32'h0);
  endtask
  // Verdict and end of run
  task automatic give_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    t_full();
    t_no_marker();
    t_sixty();
    give_verdict();
  end
  // Watchdog against a hung interpreter
  initial begin
    #200000;
    failures++;
    give_verdict();
  end
endmodule
